/* design/external_bus_unit.sv */
// external bus controller: windows, chip selects, timing, ready and hold arbitration
// ------------------------------------------------------------
// What this block does
// RQ1 - single-chip or four external bus modes
// RQ2 - address width 16, 18, 20 or 24
// RQ3 - demux: address port, full or low data
// RQ4 - mux: address then data on data port
// RQ5 - cycle, tristate, latch and delay programmable
// RQ6 - four windows, select plus config pair
// RQ7 - window four over three, two over one
// RQ8 - outside windows use default config
// RQ9 - five active-low chip selects
// RQ10 - ready extends cycle until active level
// RQ11 - ready polarity chosen per window
// RQ12 - arbitration enable hands pins to controller
// RQ13 - reset as master, acknowledge driven
// RQ14 - direction bit one selects slave mode
// RQ15 - address space restrictable to smaller sizes
// RQ16 - upper port drives 8, 4, 2, 0
// RQ17 - chip selects lag latch strobe by default
// RQ18 - timing bit aligns chip selects with strobe
// RQ19 - finish cycle, float, acknowledge; request back
// ------------------------------------------------------------
`timescale 1ns/1ps
module external_bus_unit import ebc_pkg::*; (
    input wire logic clk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire bus_req_t req,
    output logic req_done,
    output logic [15:0] rdata,
    input wire bus_mode_t bus_mode,
    input wire addr_space_t addr_space,
    input wire bus_config_t default_bus_config,
    input wire bus_config_t window1_bus_config,
    input wire bus_config_t window2_bus_config,
    input wire bus_config_t window3_bus_config,
    input wire bus_config_t window4_bus_config,
    input wire addr_select_t window1_address_select,
    input wire addr_select_t window2_address_select,
    input wire addr_select_t window3_address_select,
    input wire addr_select_t window4_address_select,
    input wire logic chip_select_timing_select,
    input wire logic arbitration_enable,
    input wire logic port6_pin7_direction,
    output logic [15:0] address_port,
    output logic address_port_oe,
    output logic [7:0] upper_addr,
    output logic [7:0] upper_addr_oe,
    output logic [15:0] data_bus_port,
    output logic [1:0] data_bus_port_oe,
    input wire logic [15:0] data_bus_port_in,
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic [CS_LINES-1:0] cs_n,
    output logic ctrl_oe,
    input wire logic ready_in,
    input wire logic hold_n,
    output logic bus_request_out_n,
    output logic hold_acknowledge_n,
    output logic hold_acknowledge_oe,
    input wire logic hold_acknowledge_in_n
);

    // ------------------------------------------------------------
    // window decode
    // ------------------------------------------------------------
    typedef enum logic [2:0] {st_idle, st_addr, st_delay, st_data, st_recover, st_hold} state_t;

    state_t state_q;
    logic [3:0] cnt_q;
    bus_config_t cfg_q;
    bus_req_t req_q;
    logic [CS_LINES-1:0] cs_pick_q;
    logic [WINDOWS-1:0] hit;
    addr_select_t win_sel [WINDOWS];
    bus_config_t win_cfg [WINDOWS];
    bus_config_t cfg_d;
    logic [CS_LINES-1:0] cs_d;
    logic [23:0] addr_lim;
    logic [7:0] upper_mask;
    logic slave_mode;
    logic hold_wanted;
    logic granted;
    logic start;
    logic data_end;
    logic ready_ok;
    logic wide;
    logic muxed;

    assign win_sel[0] = window1_address_select;
    assign win_sel[1] = window2_address_select;
    assign win_sel[2] = window3_address_select;
    assign win_sel[3] = window4_address_select;
    assign win_cfg[0] = window1_bus_config;
    assign win_cfg[1] = window2_bus_config;
    assign win_cfg[2] = window3_bus_config;
    assign win_cfg[3] = window4_bus_config;

    // RQ15 space restriction
    always_comb begin
        case (addr_space)
            space_20: upper_mask = UPPER_MASK_20;
            space_18: upper_mask = UPPER_MASK_18;
            space_16: upper_mask = UPPER_MASK_16;
            default: upper_mask = UPPER_MASK_24;
        endcase
        addr_lim = {req.addr[23:16] & upper_mask, req.addr[15:0]};
    end

    // RQ6 window pairs
    for (genvar i = 0; i < WINDOWS; i++) begin : g_win
        window_match u_match (
            .addr(addr_lim),
            .sel(win_sel[i]),
            .hit(hit[i])
        );
    end

    // RQ7 window priority
    always_comb begin
        cfg_d = default_bus_config;
        cs_d = CS_IDLE;
        if (hit[3]) begin
            cfg_d = win_cfg[3];
            cs_d[4] = 1'b0;
        end else if (hit[2]) begin
            cfg_d = win_cfg[2];
            cs_d[3] = 1'b0;
        end else if (hit[1]) begin
            cfg_d = win_cfg[1];
            cs_d[2] = 1'b0;
        end else if (hit[0]) begin
            cfg_d = win_cfg[0];
            cs_d[1] = 1'b0;
        end else begin
            // RQ8 default region
            cs_d[0] = 1'b0;
        end
        // RQ9 chip select only when enabled
        if (!cfg_d.cs_enable) begin
            cs_d = CS_IDLE;
        end
    end

    // ------------------------------------------------------------
    // arbitration terms
    // ------------------------------------------------------------
    // RQ12 pins owned once enabled
    assign slave_mode = arbitration_enable && port6_pin7_direction;
    assign hold_wanted = arbitration_enable && !port6_pin7_direction && !hold_n;
    // RQ14 slave runs only when granted
    assign granted = !slave_mode || !hold_acknowledge_in_n;
    assign start = req_valid && !req_done && granted && !hold_wanted && bus_mode != mode_single_chip;
    // RQ11 per window polarity
    assign ready_ok = (ready_in == cfg_q.ready_polarity);
    // RQ10 ready handshake
    assign data_end = (cnt_q == CNT_ZERO) && (!cfg_q.ready_enable || ready_ok);
    assign wide = (cfg_q.bus_mode == mode_demux16) || (cfg_q.bus_mode == mode_mux16);
    assign muxed = (cfg_q.bus_mode == mode_mux16) || (cfg_q.bus_mode == mode_mux8);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // RQ5 programmable phases
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= st_idle;
            cnt_q <= CNT_ZERO;
        end else begin
            case (state_q)
                st_idle: begin
                    if (hold_wanted) begin
                        state_q <= st_hold;
                    end else if (start) begin
                        state_q <= st_addr;
                        cnt_q <= {3'h0, cfg_d.ale_extend};
                    end
                end
                st_addr: begin
                    if (cnt_q != CNT_ZERO) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else if (cfg_q.rw_delay) begin
                        state_q <= st_delay;
                    end else begin
                        state_q <= st_data;
                        cnt_q <= cfg_q.mem_cycle_wait;
                    end
                end
                st_delay: begin
                    state_q <= st_data;
                    cnt_q <= cfg_q.mem_cycle_wait;
                end
                st_data: begin
                    if (cnt_q != CNT_ZERO) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else if (data_end) begin
                        state_q <= st_recover;
                        cnt_q <= {3'h0, cfg_q.tristate_wait};
                    end
                end
                st_recover: begin
                    if (cnt_q != CNT_ZERO) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else begin
                        state_q <= st_idle;
                    end
                end
                st_hold: begin
                    // RQ19 leave hold on release
                    if (hold_n || !arbitration_enable) begin
                        state_q <= st_idle;
                    end
                end
                default: state_q <= st_idle;
            endcase
        end
    end

    // latch request and configuration at start
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cfg_q <= default_bus_config;
            req_q <= '0;
            cs_pick_q <= CS_IDLE;
        end else if (state_q == st_idle && start) begin
            cfg_q <= cfg_d;
            req_q <= '{addr: addr_lim, wr: req.wr, wdata: req.wdata};
            cs_pick_q <= cs_d;
        end
    end

    // ------------------------------------------------------------
    // strobes and chip selects
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
        end else begin
            ale <= (state_q == st_idle && start) || (state_q == st_addr && cnt_q != CNT_ZERO);
            rd_n <= !((state_q == st_addr && cnt_q == CNT_ZERO && !cfg_q.rw_delay && !req_q.wr)
                      || (state_q == st_delay && !req_q.wr)
                      || (state_q == st_data && !data_end && !req_q.wr));
            wr_n <= !((state_q == st_addr && cnt_q == CNT_ZERO && !cfg_q.rw_delay && req_q.wr)
                      || (state_q == st_delay && req_q.wr)
                      || (state_q == st_data && !data_end && req_q.wr));
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cs_n <= CS_IDLE;
        end else if (state_q == st_idle && start && chip_select_timing_select) begin
            // RQ18 change with strobe
            cs_n <= cs_d;
        end else if (state_q == st_addr && ale && !chip_select_timing_select) begin
            // RQ17 one phase later
            cs_n <= cs_pick_q;
        end else if (state_q == st_recover && cnt_q == CNT_ZERO) begin
            cs_n <= CS_IDLE;
        end
    end

    // ------------------------------------------------------------
    // address and data lines
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            address_port <= DATA_ZERO;
            address_port_oe <= 1'b0;
            upper_addr <= 8'h00;
            upper_addr_oe <= 8'h00;
        end else if (state_q == st_idle && start) begin
            // RQ2 upper port width
            // RQ16 lines per space
            upper_addr <= addr_lim[23:16];
            upper_addr_oe <= upper_mask;
            // RQ3 demux address port
            address_port <= addr_lim[15:0];
            address_port_oe <= (cfg_d.bus_mode == mode_demux16) || (cfg_d.bus_mode == mode_demux8);
        end else if (state_q == st_hold || (state_q == st_recover && cnt_q == CNT_ZERO && slave_mode)) begin
            upper_addr_oe <= 8'h00;
            address_port_oe <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            data_bus_port <= DATA_ZERO;
            data_bus_port_oe <= LANES_OFF;
        end else if (state_q == st_idle && start) begin
            if (cfg_d.bus_mode == mode_mux16 || cfg_d.bus_mode == mode_mux8) begin
                // RQ4 address phase
                data_bus_port <= addr_lim[15:0];
                data_bus_port_oe <= LANES_ALL;
            end else if (req.wr) begin
                data_bus_port <= req.wdata;
                data_bus_port_oe <= (cfg_d.bus_mode == mode_demux16) ? LANES_ALL : LANES_LOW;
            end else begin
                data_bus_port_oe <= LANES_OFF;
            end
        end else if (state_q == st_addr && cnt_q == CNT_ZERO && muxed) begin
            // RQ4 data phase
            data_bus_port <= req_q.wdata;
            data_bus_port_oe <= !req_q.wr ? LANES_OFF : (wide ? LANES_ALL : LANES_LOW);
        end else if (state_q == st_data && data_end) begin
            data_bus_port_oe <= LANES_OFF;
        end
    end

    // RQ3 byte or word capture
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata <= DATA_ZERO;
            req_done <= 1'b0;
        end else begin
            req_done <= (state_q == st_data && data_end)
                        || (state_q == st_idle && bus_mode == mode_single_chip && req_valid && !req_done);
            if (state_q == st_data && data_end && !req_q.wr) begin
                rdata <= wide ? data_bus_port_in : {8'h00, data_bus_port_in[7:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // arbitration pins
    // ------------------------------------------------------------
    // RQ1 single chip leaves control lines undriven
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_oe <= 1'b0;
        end else begin
            ctrl_oe <= bus_mode != mode_single_chip && state_q != st_hold
                       && !(slave_mode && state_q == st_idle && !start);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            // RQ13 master after reset
            hold_acknowledge_n <= 1'b1;
            hold_acknowledge_oe <= 1'b1;
            bus_request_out_n <= 1'b1;
        end else begin
            // RQ14 acknowledge becomes input
            hold_acknowledge_oe <= !port6_pin7_direction;
            // RQ19 acknowledge while held
            hold_acknowledge_n <= !(arbitration_enable && state_q == st_hold && !hold_n);
            // RQ19 request bus back
            bus_request_out_n <= !(arbitration_enable && req_valid && !req_done
                                   && (state_q == st_hold || (slave_mode && state_q == st_idle)));
        end
    end

endmodule // external_bus_unit

/* design/ebc_pkg.sv */
// shared types and constants of the external bus unit
package ebc_pkg;

    // ------------------------------------------------------------
    // bus modes and address spaces
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        mode_single_chip,
        mode_demux16,
        mode_mux16,
        mode_mux8,
        mode_demux8
    } bus_mode_t;

    typedef enum logic [1:0] {
        space_24,
        space_20,
        space_18,
        space_16
    } addr_space_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic cs_enable;
        logic ready_enable;
        logic ready_polarity;
        logic ale_extend;
        logic rw_delay;
        logic tristate_wait;
        logic [3:0] mem_cycle_wait;
        bus_mode_t bus_mode;
    } bus_config_t;

    typedef struct packed {
        logic [11:0] base;
        logic [3:0] size;
    } addr_select_t;

    typedef struct packed {
        logic [23:0] addr;
        logic wr;
        logic [15:0] wdata;
    } bus_req_t;

    // ------------------------------------------------------------
    // reset values, field positions, counts
    // ------------------------------------------------------------
    localparam int WINDOWS = 4;
    localparam int CS_LINES = WINDOWS + 1;
    localparam int WIN_GRAIN = 12;
    localparam logic [CS_LINES-1:0] CS_IDLE = 5'h1f;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [7:0] UPPER_MASK_24 = 8'hff;
    localparam logic [7:0] UPPER_MASK_20 = 8'h0f;
    localparam logic [7:0] UPPER_MASK_18 = 8'h03;
    localparam logic [7:0] UPPER_MASK_16 = 8'h00;
    localparam logic [15:0] DATA_ZERO = 16'h0000;
    localparam logic [1:0] LANES_OFF = 2'h0;
    localparam logic [1:0] LANES_LOW = 2'h1;
    localparam logic [1:0] LANES_ALL = 2'h3;

endpackage

/* design/window_match.sv */
// address window hit detector
`timescale 1ns/1ps
module window_match import ebc_pkg::*; (
    input wire logic [23:0] addr,
    input wire addr_select_t sel,
    output logic hit
);
    logic [11:0] mask;

    // window of 4 kbyte times two to the size field, aligned to its size
    always_comb begin
        mask = 12'hfff << sel.size;
        hit = ((addr[23:WIN_GRAIN] & mask) == (sel.base & mask)) && (sel.size != 4'hf);
    end
endmodule // window_match

/* tb/ebc_chk.sv */
// port checker for the external bus unit
`timescale 1ns/1ps
module ebc_chk import ebc_pkg::*; (
    input wire logic clk,
    input wire logic rstn,
    input wire bus_mode_t bus_mode,
    input wire addr_space_t addr_space,
    input wire logic chip_select_timing_select,
    input wire logic ale,
    input wire logic [CS_LINES-1:0] cs_n,
    input wire logic [7:0] upper_addr_oe,
    input wire logic [1:0] data_bus_port_oe,
    input wire logic address_port_oe,
    input wire logic ctrl_oe,
    input wire logic hold_acknowledge_n,
    input wire logic hold_acknowledge_oe
);
    // --------
    // properties
    // --------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [7:0] mask_w;
    assign mask_w = addr_space == space_24 ? UPPER_MASK_24 : addr_space == space_20 ? UPPER_MASK_20 :
        addr_space == space_18 ? UPPER_MASK_18 : UPPER_MASK_16;
    reset_idle_a: assert property (disable iff (1'b0) !rstn |=> cs_n == CS_IDLE && !ale && hold_acknowledge_oe)
        else $error("outputs not idle after reset");
    one_select_a: assert property ($onehot0(~cs_n))
        else $error("more than one chip select low");
    single_quiet_a: assert property (bus_mode == mode_single_chip && $past(bus_mode) == mode_single_chip |-> !ale)
        else $error("latch strobe in single chip mode");
    upper_mask_a: assert property (ale |-> upper_addr_oe == mask_w)
        else $error("upper address enables do not match space");
    mux_address_a: assert property (ale && bus_mode inside {mode_mux16, mode_mux8} |-> data_bus_port_oe == LANES_ALL)
        else $error("multiplexed address not on data port");
    cs_early_a: assert property ($rose(ale) && chip_select_timing_select |-> cs_n != CS_IDLE)
        else $error("chip select late with early timing");
    cs_late_a: assert property ($rose(ale) && !chip_select_timing_select |-> cs_n == CS_IDLE ##1 cs_n != CS_IDLE)
        else $error("chip select not one cycle after strobe");
    hold_float_a: assert property (!hold_acknowledge_n && hold_acknowledge_oe |-> !ctrl_oe && !address_port_oe)
        else $error("bus driven while hold acknowledged");
    cover property (ale && chip_select_timing_select);
    cover property (!hold_acknowledge_n && hold_acknowledge_oe);
    cover property (!hold_acknowledge_oe);
endmodule // ebc_chk

bind external_bus_unit ebc_chk chk_u (.clk, .rstn, .bus_mode, .addr_space, .chip_select_timing_select, .ale,
    .cs_n, .upper_addr_oe, .data_bus_port_oe, .address_port_oe, .ctrl_oe, .hold_acknowledge_n, .hold_acknowledge_oe);

/* tb/ebc_mem_model.sv */
// behavioural memory on the far side of the external bus
`timescale 1ns/1ps
module ebc_mem_model import ebc_pkg::*; (
    input wire logic clk,
    input wire bus_mode_t bus_mode,
    input wire logic [15:0] address_port,
    input wire logic [7:0] upper_addr,
    input wire logic [7:0] upper_addr_oe,
    input wire logic [15:0] data_bus_port,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [4:0] cs_n,
    input wire logic rdy_level,
    input wire logic [3:0] rdy_delay,
    output logic [15:0] data_bus_port_in,
    output logic ready_in,
    output logic [23:0] seen_addr,
    output logic [4:0] seen_cs
);
    logic [15:0] mem [16];
    logic [15:0] last_q;
    logic [3:0] wait_q;
    // --------
    // address latch, storage, ready
    // --------
    always_ff @(posedge clk) begin
        if (ale) begin
            seen_addr <= {upper_addr & upper_addr_oe, bus_mode inside {mode_mux16, mode_mux8} ? data_bus_port : address_port};
        end
        if (!rd_n || !wr_n) begin
            seen_cs <= cs_n;
            wait_q <= wait_q + 4'(wait_q != 4'hf);
        end else begin
            wait_q <= 4'h0;
        end
        if (!wr_n) mem[seen_addr[3:0]] <= data_bus_port;
        if (!rd_n) last_q <= data_bus_port_in;
    end
    // released lines show the inverse of the last value
    assign data_bus_port_in = rd_n ? ~last_q : mem[seen_addr[3:0]];
    assign ready_in = wait_q >= rdy_delay ? rdy_level : ~rdy_level;
endmodule // ebc_mem_model

/* tb/external_bus_unit_bench.sv */
// self-checking bench for the external bus unit
`timescale 1ns/1ps
module external_bus_unit_bench import ebc_pkg::*; ();
    logic clk, rstn, req_valid, req_done, chip_select_timing_select, arbitration_enable, port6_pin7_direction;
    logic address_port_oe, ale, rd_n, wr_n, ctrl_oe, ready_in, hold_n, bus_request_out_n, hold_acknowledge_n;
    logic hold_acknowledge_oe, hold_acknowledge_in_n, rdy_level;
    bus_req_t req;
    bus_mode_t bus_mode;
    addr_space_t addr_space;
    bus_config_t default_bus_config, window1_bus_config, window2_bus_config, window3_bus_config, window4_bus_config;
    addr_select_t window1_address_select, window2_address_select, window3_address_select, window4_address_select;
    logic [15:0] rdata, address_port, data_bus_port, data_bus_port_in;
    logic [7:0] upper_addr, upper_addr_oe;
    logic [1:0] data_bus_port_oe;
    logic [4:0] cs_n, seen_cs;
    logic [23:0] seen_addr;
    logic [3:0] rdy_delay;
    int mismatches, n_checks, cycles, n0;

    external_bus_unit dut_u (.clk, .rstn, .req_valid, .req, .req_done, .rdata, .bus_mode, .addr_space,
        .default_bus_config, .window1_bus_config, .window2_bus_config, .window3_bus_config, .window4_bus_config,
        .window1_address_select, .window2_address_select, .window3_address_select, .window4_address_select,
        .chip_select_timing_select, .arbitration_enable, .port6_pin7_direction, .address_port, .address_port_oe,
        .upper_addr, .upper_addr_oe, .data_bus_port, .data_bus_port_oe, .data_bus_port_in, .ale, .rd_n, .wr_n,
        .cs_n, .ctrl_oe, .ready_in, .hold_n, .bus_request_out_n, .hold_acknowledge_n, .hold_acknowledge_oe,
        .hold_acknowledge_in_n);
    ebc_mem_model mem_u (.clk, .bus_mode, .address_port, .upper_addr, .upper_addr_oe, .data_bus_port, .ale,
        .rd_n, .wr_n, .cs_n, .rdy_level, .rdy_delay, .data_bus_port_in, .ready_in, .seen_addr, .seen_cs);

    // --------
    // helpers
    // --------
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic complete_run;
        if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic bus_config_t mk(input logic [3:0] w, input logic re, input logic rp);
        return '{1'b1, re, rp, 1'b0, 1'b0, 1'b0, w, bus_mode};
    endfunction
    task automatic setup(input bus_mode_t m);
        @(negedge clk);
        bus_mode = m;
        default_bus_config = mk(4'h0, 1'b0, 1'b0);
        window1_bus_config = default_bus_config;
        window2_bus_config = default_bus_config;
        window3_bus_config = default_bus_config;
        window4_bus_config = default_bus_config;
    endtask
    task automatic start(input logic [23:0] a, input logic w);
        @(negedge clk);
        req_valid = 1'b1;
        req = '{a, w, 16'ha5c3};
    endtask
    task automatic finish(output int n);
        n = 0;
        while (req_done !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("req_done", 1'b1, req_done);
        req_valid = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    task automatic access(input logic [23:0] a, input logic w, output int n);
        start(a, w);
        finish(n);
    endtask

    // --------
    // scenarios
    // --------
    task automatic modes_test;
        bus_mode_t m[4] = '{mode_demux16, mode_mux16, mode_mux8, mode_demux8};
        int n;
        for (int i = 0; i < 8; i++) begin
            setup(m[i/2]);
            chip_select_timing_select = i[0];
            access(24'h000102, 1'b1, n);
            access(24'h000102, 1'b0, n);
            chk("rdata", i > 3 ? 16'h00c3 : 16'ha5c3, rdata);
            chk("cs_n", 5'h1e, seen_cs);
        end
        setup(mode_single_chip);
        access(24'h000102, 1'b0, n);
        chk("rdata", 16'h00c3, rdata);
        chk("ctrl_oe", 1'b0, ctrl_oe);
    endtask
    task automatic window_test;
        logic [23:0] a[3] = '{24'h010010, 24'h020020, 24'h030030};
        logic [4:0] e[3] = '{5'h1b, 5'h0f, 5'h1e};
        int n;
        setup(mode_demux16);
        window1_address_select = '{12'h010, 4'h0};
        window2_address_select = '{12'h010, 4'h0};
        window3_address_select = '{12'h020, 4'h0};
        window4_address_select = '{12'h020, 4'h0};
        for (int i = 0; i < 3; i++) begin
            access(a[i], 1'b0, n);
            chk("cs_n", e[i], seen_cs);
        end
    endtask
    task automatic timing_ready_test;
        int n;
        access(24'h000100, 1'b0, n0);
        default_bus_config.mem_cycle_wait = 4'h3;
        access(24'h000100, 1'b0, n);
        chk("wait cycles", 24'(n0 + 3), 24'(n));
        rdy_delay = 4'h5;
        for (int p = 0; p < 2; p++) begin
            rdy_level = p[0];
            default_bus_config = mk(4'h0, 1'b1, p[0]);
            access(24'h000100, 1'b0, n);
            chk("ready wait", 1'b1, n >= n0 + 4 && n <= n0 + 6);
        end
        rdy_delay = 4'h0;
        default_bus_config = mk(4'h0, 1'b0, 1'b0);
        default_bus_config.ale_extend = 1'b1;
        default_bus_config.rw_delay = 1'b1;
        default_bus_config.tristate_wait = 1'b1;
        access(24'h000100, 1'b0, n);
        chk("phase cycles", 24'(n0 + 2), 24'(n));
        default_bus_config = mk(4'h0, 1'b0, 1'b0);
    endtask
    task automatic space_test;
        addr_space_t s[4] = '{space_24, space_20, space_18, space_16};
        logic [7:0] m[4] = '{8'hff, 8'h0f, 8'h03, 8'h00};
        int n;
        for (int i = 0; i < 4; i++) begin
            addr_space = s[i];
            access(24'hab4000, 1'b0, n);
            chk("upper address", m[i] & 8'hab, seen_addr[23:16]);
        end
        addr_space = space_24;
    endtask
    task automatic hold_test;
        int n;
        arbitration_enable = 1'b1;
        hold_n = 1'b0;
        start(24'h000100, 1'b0);
        repeat (3) @(negedge clk);
        chk("hold_ack", 1'b0, hold_acknowledge_n);
        chk("ctrl_oe", 1'b0, ctrl_oe);
        chk("bus_request", 1'b0, bus_request_out_n);
        hold_n = 1'b1;
        finish(n);
        chk("hold_ack", 1'b1, hold_acknowledge_n);
        port6_pin7_direction = 1'b1;
        start(24'h000100, 1'b0);
        repeat (3) @(negedge clk);
        chk("ack_oe", 1'b0, hold_acknowledge_oe);
        chk("bus_request", 1'b0, bus_request_out_n);
        hold_acknowledge_in_n = 1'b0;
        finish(n);
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        addr_space = space_24;
        chip_select_timing_select = 1'b0;
        arbitration_enable = 1'b0;
        port6_pin7_direction = 1'b0;
        hold_n = 1'b1;
        hold_acknowledge_in_n = 1'b1;
        rdy_level = 1'b0;
        rdy_delay = 4'h0;
        bus_mode = mode_demux16;
        default_bus_config = mk(4'h0, 1'b0, 1'b0);
        window1_bus_config = default_bus_config;
        window2_bus_config = default_bus_config;
        window3_bus_config = default_bus_config;
        window4_bus_config = default_bus_config;
        window1_address_select = '{12'h000, 4'hf};
        window2_address_select = '{12'h000, 4'hf};
        window3_address_select = '{12'h000, 4'hf};
        window4_address_select = '{12'h000, 4'hf};
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        chk("ack_oe", 1'b1, hold_acknowledge_oe);
        modes_test();
        window_test();
        timing_ready_test();
        space_test();
        hold_test();
        complete_run();
    end
endmodule // external_bus_unit_bench
